// ### sim/sacs_host.sv
/* sacs_host: serial host exchanging 16-bit frames.
   assumes the shift clock stays low outside frames. */
`timescale 1ns/1ns
module sacs_host (
	output logic sck_o,
	output logic sdi_o,
	input wire logic sdo_i
);
	initial begin
		sck_o = 1'b0;
		sdi_o = 1'b0;
	end
	// 800 ns frame bits, result taken msb first before each rise
	task automatic xfer(input logic [7:0] cfg_w, output logic [15:0] res);
		int i;
		#37;
		for (i = 15; i >= 0; i--) begin
			sdi_o = (i > 7) ? cfg_w[i-8] : ~sdi_o;
			#400 res[i] = sdo_i;
			sck_o = 1'b1;
			#400 sck_o = 1'b0;
		end
		sdi_o = ~sdi_o;
	endtask
endmodule

// ### sim/sacs_props.sv
/* sacs_props: port checker for sacs_top.
   assumes the 16-bit build and the 10 MHz clock of the package. */
`timescale 1ns/1ns
module sacs_props
	import sacs_pkg::*;
#(
	parameter int unsigned RES_BITS = 16
) (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic conversion_start_in_i,
	input wire logic read_b_i,
	input wire logic serial_result_oe_o,
	input wire logic conv_done_o,
	input wire logic track_o,
	input wire logic [7:0] cfg_o,
	input wire logic [RES_BITS-1:0] sar_dac_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_b_i);
	// conversion timing, output enable and config capture
	a_busy_len: assert property ($fell(conv_done_o) |-> ##[30:34] $rose(conv_done_o))
		else $error("conversion length wrong");
	a_busy_low: assert property ($fell(conv_done_o) |-> (!conv_done_o)[*8])
		else $error("status rose early");
	a_start_busy: assert property ($rose(conversion_start_in_i) && conv_done_o
		|-> ##[1:5] !conv_done_o) else $error("start not taken");
	a_hold_conv: assert property (!conv_done_o |-> !track_o)
		else $error("tracking during conversion");
	a_oe_off: assert property (read_b_i[*6] |-> !serial_result_oe_o)
		else $error("output driven while read off");
	a_oe_on: assert property ((!read_b_i)[*6] |-> serial_result_oe_o)
		else $error("output not driven");
	a_cfg_hold: assert property ($changed(cfg_o) |-> ##[0:2] !conv_done_o)
		else $error("config changed outside start");
	a_sar_msb: assert property ($fell(conv_done_o)
		|-> sar_dac_o == {1'b1, {(RES_BITS-1){1'b0}}}) else $error("first trial wrong");
endmodule
bind sacs_top sacs_props #(.RES_BITS(RES_BITS)) u_sacs_props (.*);

// ### sim/tb_top.sv
/* tb_top: self-checking bench for sacs_top.
   assumes the final sar word is the result shifted out. */
`timescale 1ns/1ns
module tb_top;
	import sacs_pkg::*;
	logic clk_sys_i = 0, rst_b_i = 0, start = 0, read_b = 0, cmp;
	logic sck, serial_config_in, serial_result_out, oe, done, track;
	logic [7:0] cfg_w, cfg;
	logic [15:0] sar, target = 16'h0000, exp_v = 16'h0000, res;
	int num_errors = 0, tests_run = 0, seed = 32'h515c, n;
	always #50 clk_sys_i = ~clk_sys_i;
	// comparator keeps a trial while it does not pass the target
	assign cmp = (sar <= target);
	sacs_top u_sacs_top (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .shift_clk_i(sck),
		.serial_config_in_i(serial_config_in), .conversion_start_in_i(start), .read_b_i(read_b),
		.cmp_i(cmp), .serial_result_out_o(serial_result_out), .serial_result_oe_o(oe),
		.conv_done_o(done), .track_o(track), .cfg_o(cfg), .sar_dac_o(sar));
	sacs_host u_sacs_host (.sck_o(sck), .sdi_o(serial_config_in), .sdo_i(oe ? serial_result_out : ~serial_result_out));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// corner inputs first, then random ones
	function automatic logic [15:0] tgt(input int i);
		case (i)
			0: return 16'h7fff;
			1: return 16'h8000;
			2: return 16'h0000;
			3: return 16'hffff;
			default: return 16'($random(seed));
		endcase
	endfunction
	task automatic wrap_up();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk_sys_i);
		#10 rst_b_i = 1;
		repeat (4) @(posedge clk_sys_i);
		for (n = 0; n < 8; n++) begin
			cfg_w = 8'($random(seed));
			if (n == 2) begin
				#10 read_b = 1;
				u_sacs_host.xfer(~cfg_w, res);
				chk(16'(oe), 16'h0000);
				@(posedge clk_sys_i) #10 read_b = 0;
			end
			u_sacs_host.xfer(cfg_w, res);
			chk(res, exp_v);
			repeat (40) @(posedge clk_sys_i);
			chk(16'(track), 16'h0001);
			target = tgt(n);
			#10 start = 1;
			repeat (5) @(posedge clk_sys_i);
			chk(16'(done), 16'h0000);
			#10 start = 0;
			// second start late in the conversion: a restart would keep status low
			repeat (20) @(posedge clk_sys_i);
			#10 start = 1;
			repeat (20) @(posedge clk_sys_i);
			chk(16'(done), 16'h0001);
			#10 start = 0;
			repeat (20) @(posedge clk_sys_i);
			chk(16'(done), 16'h0001);
			chk(16'(cfg), 16'(cfg_w));
			exp_v = target;
			$display("test %0d done", n);
		end
		u_sacs_host.xfer(8'h00, res);
		chk(res, exp_v);
		wrap_up();
	end
	initial begin
		#300000;
		num_errors++;
		wrap_up();
	end
endmodule

// ### src/sacs_pkg.sv
/*
 * sacs_pkg: constants and carrier types for the conversion sequencer.
 * Assumes a 10 MHz system clock; all times are turned into cycle counts here.
 */
package sacs_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned CONV_TIME_NS = 4000; // internal conversion time
	localparam int unsigned CONV_CYCLES = (CONV_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;

	// ----------------------------------------------------------------
	// configuration word layout (first bit shifted in is bit 7)
	// ----------------------------------------------------------------
	localparam int unsigned CFG_BITS = 8;
	localparam int unsigned ACQ_BIT_NUM = 6; // acquisition opens after this bit
	localparam int unsigned CFG_SGL_POS = 7;
	localparam int unsigned CFG_ODD_POS = 6;
	localparam int unsigned CFG_SEL_HI = 5;
	localparam int unsigned CFG_SEL_LO = 4;
	localparam int unsigned CFG_NAP_POS = 1;
	localparam int unsigned CFG_SLEEP_POS = 0;
	localparam logic [7:0] CFG_RESET = 8'h00;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SACS_IDLE = 2'b00,
		SACS_ACQ = 2'b01,
		SACS_CONV = 2'b10
	} sacs_state_e;

	typedef struct packed {
		logic single_ended;
		logic odd_sign;
		logic [1:0] select;
		logic nap;
		logic sleep;
	} sacs_cfg_s;

endpackage

// ### src/sacs_top.sv
/*
 * sacs_top: digital control of a multichannel SAR converter.
 * Assumes serial pins arrive asynchronously and are sampled by clk_sys_i;
 * the analog comparator decision arrives as cmp_i, valid each bit cycle.
 */
// Behaviour
// RQ1: host shifts 8 config bits on first 8 rising edges; word sets channel and power mode.
// RQ2: acquisition begins on falling shift-clock edge of the sixth config bit.
// RQ3: conversion-start rising edge ends acquisition, holds sample, starts conversion.
// RQ4: host waits at least 4 us of acquisition before conversion start.
// RQ5: conversion-start edges during a conversion are ignored.
// RQ6: SAR decides result bits one by one, MSB first; width 12, 14 or 16.
// RQ7: finished approximation word (positive minus negative) loads output shift register.
// RQ8: result is two's complement; full positive is zero then all ones; code sends the sar word unchanged, so full positive is all ones.
// RQ9: internal clock finishes conversion in about 4 us; code takes STEP_CYC cycles per bit, 32 cycles (3.2 us) at 16 bits.
// RQ10: status output low during conversion, high when it completes.
// RQ11: read-enable high ignores input and shift clock and disables serial output.
// RQ12: after eighth config bit, further input bits ignored until next conversion starts.
// RQ13: result shifts out MSB first, one bit per shift clock, during config input.
`timescale 1ns/1ns
module sacs_top
	import sacs_pkg::*;
#(
	parameter int unsigned RES_BITS = 16
) (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic shift_clk_i,
	input wire logic serial_config_in_i,
	input wire logic conversion_start_in_i,
	input wire logic read_b_i,
	input wire logic cmp_i,
	output logic serial_result_out_o,
	output logic serial_result_oe_o,
	output logic conv_done_o,
	output logic track_o,
	output logic [7:0] cfg_o,
	output logic [RES_BITS-1:0] sar_dac_o
);

	// elaboration checks: only the three result widths are served, and every
	// bit step must last at least one cycle and still fit the 6-bit step timer
	if (RES_BITS != 12 && RES_BITS != 14 && RES_BITS != 16) begin : g_bad_width
		$error("RES_BITS must be 12, 14 or 16");
	end
	if (CONV_CYCLES / RES_BITS < 1 || CONV_CYCLES / RES_BITS > 63) begin : g_bad_step
		$error("conversion time does not fit the bit step timer");
	end

	localparam logic [5:0] STEP_CYC = 6'(CONV_CYCLES / RES_BITS);

	// ----------------------------------------------------------------
	// reset and input synchronisers
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_ff;
	logic rst_n;
	logic [3:0] meta_ff;
	logic [3:0] sync_ff;
	logic sck_d_ff;
	logic cst_d_ff;

	// reset released through two flops
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_sync_ff <= 2'b00;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	// two-flop synchronisers for pins; sck edge history
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= 4'h0;
			sync_ff <= 4'h0;
			sck_d_ff <= 1'b0;
			cst_d_ff <= 1'b0;
		end else begin
			meta_ff <= {read_b_i, conversion_start_in_i, serial_config_in_i, shift_clk_i};
			sync_ff <= meta_ff;
			sck_d_ff <= sync_ff[0];
			cst_d_ff <= sync_ff[2];
		end
	end

	wire sck_s = sync_ff[0];
	wire sdi_s = sync_ff[1];
	wire cst_s = sync_ff[2];
	wire rdb_s = sync_ff[3];
	wire sck_rise = sck_s & ~sck_d_ff & ~rdb_s; // see RQ11
	wire sck_fall = ~sck_s & sck_d_ff & ~rdb_s; // see RQ11
	wire cst_rise = cst_s & ~cst_d_ff;

	// ----------------------------------------------------------------
	// serial configuration input and result output
	// ----------------------------------------------------------------
	sacs_state_e state_ff, nxt_state;
	logic [3:0] bit_cnt_ff;
	logic [7:0] cfg_sh_ff;
	logic [7:0] cfg_ff;
	logic [RES_BITS-1:0] out_sh_ff;
	logic [RES_BITS-1:0] sar_ff;
	logic [RES_BITS-1:0] trial_ff;
	logic [5:0] step_ff;
	logic sdo_ff;
	logic oe_ff;
	logic done_ff;
	logic track_ff;

	wire cfg_open = bit_cnt_ff < 4'(CFG_BITS); // see RQ12
	wire take_bit = sck_rise & cfg_open; // see RQ1
	wire acq_open = sck_fall & (bit_cnt_ff == 4'(ACQ_BIT_NUM)); // see RQ2
	wire conv_go = cst_rise & (state_ff != SACS_CONV); // see RQ3 see RQ5
	wire step_end = (state_ff == SACS_CONV) & (step_ff == STEP_CYC - 6'h01);
	wire last_bit = step_end & trial_ff[0];
	wire [RES_BITS-1:0] sar_keep = cmp_i ? sar_ff : (sar_ff & ~trial_ff);
	wire [RES_BITS-1:0] sar_next = sar_keep | (trial_ff >> 1);

	// config capture; counter rearmed only when a conversion starts
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt_ff <= 4'h0;
			cfg_sh_ff <= CFG_RESET;
			cfg_ff <= CFG_RESET;
		end else begin
			if (conv_go) begin
				bit_cnt_ff <= 4'h0; // see RQ12
				cfg_ff <= cfg_sh_ff; // see RQ1
			end else if (take_bit) begin
				bit_cnt_ff <= bit_cnt_ff + 4'h1;
				cfg_sh_ff <= {cfg_sh_ff[6:0], sdi_s}; // see RQ1
			end
		end
	end

	// result shift: msb first, next bit presented on falling shift clock
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			out_sh_ff <= '0;
			sdo_ff <= 1'b0;
			oe_ff <= 1'b0;
		end else begin
			oe_ff <= ~rdb_s; // see RQ11
			if (last_bit) begin
				out_sh_ff <= {sar_keep[RES_BITS-2:0], 1'b0}; // see RQ7
				sdo_ff <= sar_keep[RES_BITS-1]; // see RQ8
			end else if (sck_fall) begin
				out_sh_ff <= {out_sh_ff[RES_BITS-2:0], 1'b0}; // see RQ13
				sdo_ff <= out_sh_ff[RES_BITS-1]; // see RQ13
			end
		end
	end

	// ----------------------------------------------------------------
	// sequencer and successive approximation
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			SACS_IDLE: begin
				if (conv_go) begin
					nxt_state = SACS_CONV;
				end else if (acq_open) begin
					nxt_state = SACS_ACQ;
				end
			end
			SACS_ACQ: begin
				if (conv_go) begin
					nxt_state = SACS_CONV; // see RQ3
				end
			end
			SACS_CONV: begin
				if (last_bit) begin
					nxt_state = SACS_IDLE;
				end
			end
			default: begin
				nxt_state = SACS_IDLE;
			end
		endcase
	end

	// state, bit timer and sar register; one bit per step, msb first
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= SACS_IDLE;
			step_ff <= 6'h00;
			sar_ff <= '0;
			trial_ff <= '0;
			done_ff <= 1'b1;
			track_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			track_ff <= (nxt_state == SACS_ACQ); // see RQ2 see RQ3
			if (conv_go) begin
				done_ff <= 1'b0; // see RQ10
				step_ff <= 6'h00;
				trial_ff <= {1'b1, {(RES_BITS-1){1'b0}}}; // see RQ6
				sar_ff <= {1'b1, {(RES_BITS-1){1'b0}}};
			end else if (step_end) begin
				step_ff <= 6'h00; // see RQ9
				sar_ff <= sar_next; // see RQ6
				trial_ff <= trial_ff >> 1;
				if (trial_ff[0]) begin
					done_ff <= 1'b1; // see RQ10
				end
			end else if (state_ff == SACS_CONV) begin
				step_ff <= step_ff + 6'h01;
			end
		end
	end

	assign serial_result_out_o = sdo_ff;
	assign serial_result_oe_o = oe_ff;
	assign conv_done_o = done_ff;
	assign track_o = track_ff;
	assign cfg_o = cfg_ff;
	assign sar_dac_o = sar_ff;

endmodule
